// ### mrc_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the master reset/config registers
// Assumes: Registers reached by a plain internal word port at the printed byte offsets
// Notes:   Definitions only
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

`define MRC_ADDR_W          12
`define MRC_OFF_RESET_REV   12'h000
`define MRC_OFF_MASTER_CFG  12'h010
`define MRC_REG_RESET       16'h0000
`define MRC_BIT_SW_RESET    0
`define MRC_REV_LSB         8
`define MRC_REV_MSB         15
`define MRC_BIT_RX_DMA_EN   0
`define MRC_RX_BURST_LSB    1
`define MRC_RX_BURST_MSB    2
`define MRC_BIT_TX_DMA_EN   3
`define MRC_TX_BURST_LSB    4
`define MRC_TX_BURST_MSB    5
`define MRC_BIT_BYTE_ORDER  6
`define MRC_TST_PORT_LSB    7
`define MRC_TST_PORT_MSB    11
`define MRC_RX_PRIO_LSB     12
`define MRC_RX_PRIO_MSB     13
`define MRC_TX_PRIO_LSB     14
`define MRC_TX_PRIO_MSB     15
`define MRC_BURST_BASE      9'h020
`define MRC_TST_LAST_PORT   5'h0F
`define MRC_TST_HS_PORT0    5'h10
`define MRC_TST_HS_PORT1    5'h11
`define MRC_PRIO_GRP_RR     7'h00
`define MRC_PRIO_GRP_2      7'h02
`define MRC_PRIO_GRP_16     7'h10
`define MRC_PRIO_GRP_64     7'h40

`endif

// ### mrc_pkg.sv
// Purpose: Types shared by the master reset/config register bank
// Assumes: Constants live in mrc_cfg.svh
// Notes:   Types only
package mrc_pkg;
	typedef logic [1:0] mrc_code2_t;
	typedef logic [4:0] mrc_port_sel_t;
	typedef enum logic [1:0] {MRC_BURST_32, MRC_BURST_64, MRC_BURST_128, MRC_BURST_256} mrc_burst_e;
	typedef enum logic [1:0] {MRC_PRIO_RR, MRC_PRIO_2, MRC_PRIO_16, MRC_PRIO_64} mrc_prio_e;
endpackage : mrc_pkg

// ### mrc_prio_arb.sv
// Purpose: FIFO-to-DMA channel arbiter: low channels fixed priority, rest round robin
// Assumes: Request vector bit 0 is channel 1; grant is one-hot or zero, held one cycle
// Notes:   Priority group size set by a 2-bit scheme code
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_prio_arb
	import mrc_pkg::*;
#(
	parameter int N_CH = 256
) (
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	input  wire logic            clk_en,
	input  wire logic            arb_en,
	input  wire mrc_code2_t      prio_scheme,
	input  wire logic [N_CH-1:0] req,
	output logic      [N_CH-1:0] grant
);
	logic [N_CH-1:0] grp_mask;
	logic [N_CH-1:0] fixed_req;
	logic [N_CH-1:0] rr_req;
	logic [N_CH-1:0] fixed_pick;
	logic [N_CH-1:0] rr_pick;
	logic [N_CH-1:0] grant_d;
	logic [N_CH-1:0] grant_q;
	logic [$clog2(N_CH)-1:0] rr_ptr_q;
	logic [6:0] grp_size;

	assign grp_size = (prio_scheme == 2'(MRC_PRIO_2))  ? `MRC_PRIO_GRP_2  :
	                  (prio_scheme == 2'(MRC_PRIO_16)) ? `MRC_PRIO_GRP_16 :
	                  (prio_scheme == 2'(MRC_PRIO_64)) ? `MRC_PRIO_GRP_64 : `MRC_PRIO_GRP_RR;

	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_mask
			assign grp_mask[g] = (g < int'(grp_size));
		end
	endgenerate

	assign fixed_req  = req & grp_mask;
	assign rr_req     = req & ~grp_mask;
	// Lowest-numbered requester in the fixed group always wins
	assign fixed_pick = fixed_req & (~fixed_req + 1'b1);

	// Round robin: first requester at or after the pointer, wrapping
	always_comb begin
		logic [$clog2(N_CH)-1:0] idx;
		logic found;
		idx = '0;
		found = 1'b0;
		rr_pick = '0;
		for (int i = 0; i < N_CH; i++) begin
			idx = rr_ptr_q + ($clog2(N_CH))'(i);
			if (!found && rr_req[idx]) begin
				rr_pick[idx] = 1'b1;
				found = 1'b1;
			end
		end
	end

	assign grant_d = !arb_en ? '0 : (|fixed_req) ? fixed_pick : rr_pick;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			grant_q  <= '0;
			rr_ptr_q <= '0;
		end else if (clk_en) begin
			grant_q <= grant_d;
			for (int i = 0; i < N_CH; i++) begin
				if (rr_pick[i] && !(|fixed_req) && arb_en)
					rr_ptr_q <= ($clog2(N_CH))'(i + 1);
			end
		end
	end

	assign grant = grant_q;
endmodule : mrc_prio_arb

// ### mrc_master_regs.sv
// Purpose: Master reset/revision and master configuration registers with their decoded controls
// Assumes: Word register port, one access per cycle, read data registered one cycle later
// Notes:   Hardware reset is rst_n; software reset holds the master config register at default
`timescale 1ns/1ps
`include "mrc_cfg.svh"

module mrc_master_regs
	import mrc_pkg::*;
#(
	parameter int            N_CH    = 256,
	parameter int            N_PORTS = 16,
	parameter logic [7:0]    CHIP_REV = 8'h5A  // Arbitrary revision value
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [`MRC_ADDR_W-1:0]   reg_addr,
	input  wire logic [15:0]              reg_wdata,
	output logic      [15:0]              reg_rdata,
	output logic                          reg_rvalid,
	output logic                          reg_addr_err,
	output logic                          soft_reset,
	output logic                          pci_out_oe_n,
	output logic                          rx_dma_run,
	output logic                          tx_dma_run,
	output logic      [8:0]               rx_burst_max,
	output logic      [8:0]               tx_burst_max,
	input  wire logic [31:0]              pkt_word_in,
	input  wire logic                     pkt_is_reg_access,
	output logic      [31:0]              pkt_word_out,
	output logic      [N_PORTS-1:0]       tester_port_sel,
	output logic      [1:0]               tester_hs_sel,
	output logic                          tester_sel_valid,
	input  wire logic [N_CH-1:0]          rx_req,
	input  wire logic [N_CH-1:0]          tx_req,
	output logic      [N_CH-1:0]          rx_grant,
	output logic      [N_CH-1:0]          tx_grant
);
	logic          sw_rst_q;
	logic [15:0]   master_cfg_q;
	logic [15:0]   rdata_q;
	logic          rvalid_q;
	logic          addr_err_q;
	logic          rx_run_q;
	logic          tx_run_q;
	logic [8:0]    rx_burst_q;
	logic [8:0]    tx_burst_q;
	logic [31:0]   pkt_q;
	logic [N_PORTS-1:0] tport_q;
	logic [1:0]    ths_q;
	logic          tvalid_q;

	function automatic logic [8:0] burst_dwords(input mrc_code2_t code);
		burst_dwords = 9'(`MRC_BURST_BASE << code);
	endfunction : burst_dwords

	logic          hit_rr;
	logic          hit_mc;
	logic          wr_rr;
	logic          wr_mc;
	logic [15:0]   rr_view;
	logic [15:0]   rd_mux;
	logic          rx_en;
	logic          tx_en;
	logic          order_big;
	mrc_port_sel_t tsel;
	mrc_code2_t    rx_prio;
	mrc_code2_t    tx_prio;
	logic [31:0]   swapped;
	logic [N_PORTS-1:0] tport_d;
	logic [1:0]    ths_d;

	assign hit_rr = (reg_addr == `MRC_OFF_RESET_REV);
	assign hit_mc = (reg_addr == `MRC_OFF_MASTER_CFG);
	assign wr_rr  = reg_wr && hit_rr;
	// Config writes are dropped while the software reset bit is set
	assign wr_mc  = reg_wr && hit_mc && !sw_rst_q;

	// Revision byte is a constant; only the reset bit stores
	assign rr_view = {CHIP_REV, 7'h00, sw_rst_q};
	assign rd_mux  = hit_rr ? rr_view : hit_mc ? master_cfg_q : `MRC_REG_RESET;

	assign rx_en     = master_cfg_q[`MRC_BIT_RX_DMA_EN];
	assign tx_en     = master_cfg_q[`MRC_BIT_TX_DMA_EN];
	assign order_big = master_cfg_q[`MRC_BIT_BYTE_ORDER];
	assign tsel      = master_cfg_q[`MRC_TST_PORT_MSB:`MRC_TST_PORT_LSB];
	assign rx_prio   = master_cfg_q[`MRC_RX_PRIO_MSB:`MRC_RX_PRIO_LSB];
	assign tx_prio   = master_cfg_q[`MRC_TX_PRIO_MSB:`MRC_TX_PRIO_LSB];

	assign swapped = {pkt_word_in[7:0], pkt_word_in[15:8],
	                  pkt_word_in[23:16], pkt_word_in[31:24]};

	genvar p;
	generate
		for (p = 0; p < N_PORTS; p++) begin : g_tport
			assign tport_d[p] = (tsel == 5'(p)) && (tsel <= `MRC_TST_LAST_PORT);
		end
	endgenerate
	assign ths_d = {tsel == `MRC_TST_HS_PORT1, tsel == `MRC_TST_HS_PORT0};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sw_rst_q <= 1'b0;
		end else if (clk_en && wr_rr) begin
			sw_rst_q <= reg_wdata[`MRC_BIT_SW_RESET];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			master_cfg_q <= `MRC_REG_RESET;
		end else if (clk_en) begin
			if (sw_rst_q)
				master_cfg_q <= `MRC_REG_RESET;
			else if (wr_mc)
				master_cfg_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_q    <= `MRC_REG_RESET;
			rvalid_q   <= 1'b0;
			addr_err_q <= 1'b0;
		end else if (clk_en) begin
			rvalid_q   <= reg_rd;
			addr_err_q <= (reg_rd || reg_wr) && !hit_rr && !hit_mc;
			rdata_q    <= reg_rd ? rd_mux : `MRC_REG_RESET;
		end
	end

	// Enables drop immediately when the software reset bit is seen
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_run_q   <= 1'b0;
			tx_run_q   <= 1'b0;
			rx_burst_q <= `MRC_BURST_BASE;
			tx_burst_q <= `MRC_BURST_BASE;
		end else if (clk_en) begin
			rx_run_q   <= rx_en && !sw_rst_q;
			tx_run_q   <= tx_en && !sw_rst_q;
			rx_burst_q <= burst_dwords(master_cfg_q[`MRC_RX_BURST_MSB:`MRC_RX_BURST_LSB]);
			tx_burst_q <= burst_dwords(master_cfg_q[`MRC_TX_BURST_MSB:`MRC_TX_BURST_LSB]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pkt_q <= 32'h0000_0000;
		end else if (clk_en) begin
			// Register traffic (pkt_is_reg_access) ignores the byte-order bit
			pkt_q <= (order_big && !pkt_is_reg_access) ? swapped : pkt_word_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tport_q  <= '0;
			ths_q    <= 2'h0;
			tvalid_q <= 1'b0;
		end else if (clk_en) begin
			tport_q  <= tport_d;
			ths_q    <= ths_d;
			tvalid_q <= (|tport_d) || (|ths_d);
		end
	end

	mrc_prio_arb #(
		.N_CH (N_CH)
	) u_rx_arb (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.arb_en      (rx_en && !sw_rst_q),
		.prio_scheme (rx_prio),
		.req         (rx_req),
		.grant       (rx_grant)
	);

	mrc_prio_arb #(
		.N_CH (N_CH)
	) u_tx_arb (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.arb_en      (tx_en && !sw_rst_q),
		.prio_scheme (tx_prio),
		.req         (tx_req),
		.grant       (tx_grant)
	);

	// Bus drivers are released only by the hardware reset, never the soft one
	logic oe_n_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			oe_n_q <= 1'b1;
		else
			oe_n_q <= 1'b0;
	end

	assign reg_rdata     = rdata_q;
	assign reg_rvalid    = rvalid_q;
	assign reg_addr_err  = addr_err_q;
	assign soft_reset    = sw_rst_q;
	assign pci_out_oe_n  = oe_n_q;
	assign rx_dma_run    = rx_run_q;
	assign tx_dma_run    = tx_run_q;
	assign rx_burst_max  = rx_burst_q;
	assign tx_burst_max  = tx_burst_q;
	assign pkt_word_out  = pkt_q;
	assign tester_port_sel  = tport_q;
	assign tester_hs_sel    = ths_q;
	assign tester_sel_valid = tvalid_q;
endmodule : mrc_master_regs

// ### mrc_master_regs_assertions.sv
// Purpose: Port-level assertions for the master reset/config register bank
// Assumes: Bound into mrc_master_regs, one clock domain
// Notes:   Config outputs are checked for legal encodings, not their register
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module mrc_master_regs_chk #(
	parameter int         N_CH     = 256,
	parameter int         N_PORTS  = 16,
	parameter logic [7:0] CHIP_REV = 8'h5A
) (
	input wire logic                   ref_clk,
	input wire logic                   rst_n,
	input wire logic                   clk_en,
	input wire logic                   reg_rd,
	input wire logic [`MRC_ADDR_W-1:0] reg_addr,
	input wire logic [15:0]            reg_rdata,
	input wire logic                   reg_rvalid,
	input wire logic                   soft_reset,
	input wire logic                   pci_out_oe_n,
	input wire logic                   rx_dma_run,
	input wire logic                   tx_dma_run,
	input wire logic [8:0]             rx_burst_max,
	input wire logic [8:0]             tx_burst_max,
	input wire logic [31:0]            pkt_word_in,
	input wire logic                   pkt_is_reg_access,
	input wire logic [31:0]            pkt_word_out,
	input wire logic [N_PORTS-1:0]     tester_port_sel,
	input wire logic [1:0]             tester_hs_sel,
	input wire logic                   tester_sel_valid,
	input wire logic [N_CH-1:0]        rx_grant
);
	default clocking cb @(posedge ref_clk); endclocking
	a_drivers_on: assert property (disable iff (!rst_n) rst_n |=> !pci_out_oe_n)
		else $error("bus outputs released outside hardware reset");
	a_hw_clear: assert property ((!rst_n && clk_en) |=> pci_out_oe_n && !soft_reset
		&& !rx_dma_run && !tx_dma_run && rx_burst_max == `MRC_BURST_BASE)
		else $error("hardware reset left state behind");
	a_rd_answer: assert property (disable iff (!rst_n) clk_en |=> reg_rvalid == $past(reg_rd))
		else $error("read answer not one cycle after request");
	a_rev_ro: assert property (disable iff (!rst_n)
		clk_en && reg_rd && reg_addr == `MRC_OFF_RESET_REV |=> reg_rdata[15:8] == CHIP_REV)
		else $error("revision byte wrong");
	a_soft_stop: assert property (disable iff (!rst_n)
		clk_en && soft_reset |=> !rx_dma_run && !tx_dma_run)
		else $error("DMA runs during software reset");
	a_reg_order: assert property (disable iff (!rst_n)
		clk_en && pkt_is_reg_access |=> pkt_word_out == $past(pkt_word_in))
		else $error("register access was reordered");
	a_burst_code: assert property (disable iff (!rst_n) $onehot(rx_burst_max[8:5])
		&& rx_burst_max[4:0] == 5'h00 && $onehot(tx_burst_max[8:5]) && tx_burst_max[4:0] == 5'h00)
		else $error("burst limit not a legal size");
	a_tester_sel: assert property (disable iff (!rst_n) $onehot0({tester_port_sel, tester_hs_sel})
		&& tester_sel_valid == (|{tester_port_sel, tester_hs_sel}))
		else $error("tester selection inconsistent");
	a_grant_one: assert property (disable iff (!rst_n) $onehot0(rx_grant))
		else $error("more than one receive grant");
endmodule : mrc_master_regs_chk
bind mrc_master_regs mrc_master_regs_chk #(.N_CH(N_CH), .N_PORTS(N_PORTS), .CHIP_REV(CHIP_REV))
	chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.soft_reset(soft_reset), .pci_out_oe_n(pci_out_oe_n), .rx_dma_run(rx_dma_run),
	.tx_dma_run(tx_dma_run), .rx_burst_max(rx_burst_max), .tx_burst_max(tx_burst_max),
	.pkt_word_in(pkt_word_in), .pkt_is_reg_access(pkt_is_reg_access),
	.pkt_word_out(pkt_word_out), .tester_port_sel(tester_port_sel),
	.tester_hs_sel(tester_hs_sel), .tester_sel_valid(tester_sel_valid), .rx_grant(rx_grant));

// ### tb_top.sv
// Purpose: Self-checking bench for the master reset/config register bank
// Assumes: Reduced channel count; clk_en held high
// Notes:   Model keeps the two registers as integers
`timescale 1ns/1ps
`include "mrc_cfg.svh"
module tb_top;
	import mrc_pkg::*;
	localparam int         NC  = 8;
	localparam logic [7:0] REV = 8'h3C;  // Arbitrary revision value
	localparam logic [11:0] RA = `MRC_OFF_RESET_REV;
	localparam logic [11:0] MA = `MRC_OFF_MASTER_CFG;
	logic ref_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, pir = 0;
	logic [11:0]   reg_addr = '0;
	logic [15:0]   reg_wdata = '0, rdata, rd_q, tps;
	logic          rvalid, aerr, sw, oe_n, rxr, txr, hs_v, err_q;
	logic [8:0]    rxb, txb;
	logic [31:0]   pin = '0, pout;
	logic [1:0]    hs;
	logic [NC-1:0] rxq = '0, txq = '0, rxg, txg;
	int            n_mismatch = 0, check_count = 0, mc_m = 0, rst_m = 0, rx_p = 0, tx_p = 0;
	mrc_master_regs #(.N_CH(NC), .CHIP_REV(REV)) mrc_master_regs_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.reg_addr_err(aerr), .soft_reset(sw), .pci_out_oe_n(oe_n), .rx_dma_run(rxr),
		.tx_dma_run(txr), .rx_burst_max(rxb), .tx_burst_max(txb), .pkt_word_in(pin),
		.pkt_is_reg_access(pir), .pkt_word_out(pout), .tester_port_sel(tps),
		.tester_hs_sel(hs), .tester_sel_valid(hs_v), .rx_req(rxq), .tx_req(txq),
		.rx_grant(rxg), .tx_grant(txg));
	initial forever #2 ref_clk = ~ref_clk;
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Two cycles per access keeps every strobe edge free of double drives
	task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
		rd_q = rdata;
		err_q = aerr;
		if (!w) chk("rvalid", 1, rvalid);
	endtask : acc
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		acc(1, a, d);
		if (a == RA) rst_m = d[0];
		if (a == MA) mc_m = d;
		if (rst_m) mc_m = 0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		acc(0, a, 0);
		chk("rdata", a == RA ? {REV, 7'h00, rst_m[0]} : (a == MA ? mc_m : 0), rd_q);
		chk("addr_err", a != RA && a != MA, err_q);
		chk("soft_reset", rst_m[0], sw);
	endtask : rd
	// First requester at or after the pointer, wrapping
	function automatic int rr_win(input logic [NC-1:0] q, input int p);
		rr_win = 0;
		for (int k = NC - 1; k >= 0; k--)
			if (q[(p + k) % NC]) rr_win = (p + k) % NC;
	endfunction : rr_win
	// Requests stand for two edges, so the round-robin pointer moves twice
	task automatic arb(input logic [NC-1:0] q, input logic [1:0] s, input logic en,
		input logic [NC-1:0] g, inout int p);
		int n;
		int w;
		n = s == 0 ? 0 : (s == 1 ? 2 : (s == 2 ? 16 : 64));
		for (int i = 0; i < NC; i++)
			if (q[i] && i < n) n = -i - 1;
		w = rr_win(q, p);
		if (!en) chk("grant_off", 0, g);
		else if (n < 0) chk("grant_low", 1 << (-n - 1), g);
		else chk("grant_hit", q != 0 ? 1 << w : 0, g);
		chk("grant_sub", 0, g & ~q);
		if (en && n >= 0 && q != 0) begin
			p = (w + 1) % NC;
			p = (rr_win(q, p) + 1) % NC;
		end
	endtask : arb
	initial begin
		int v;
		int r;
		v = $urandom(79);
		repeat (2) @(posedge ref_clk);
		rst_n <= 1;
		#1;
		chk("oe_in_reset", 1, oe_n);
		rd(RA);
		rd(MA);
		chk("oe_running", 0, oe_n);
		wr(RA, 16'hFFFF);
		rd(RA);
		wr(MA, 16'hFFFF);
		rd(MA);
		chk("oe_soft", 0, oe_n);
		wr(RA, 16'h0000);
		for (int i = 0; i < 32; i++) begin
			v = $urandom & 16'hF07F | (i << 7);
			wr(MA, v[15:0]);
			rd(MA);
			r = $urandom;
			@(posedge ref_clk);
			pin <= r;
			pir <= i[0];
			rxq <= r[NC-1:0];
			txq <= r[NC+7:8];
			@(posedge ref_clk);
			#1;
			chk("pkt_out", v[6] && !i[0] ? {r[7:0], r[15:8], r[23:16], r[31:24]} : r, pout);
			chk("rx_run", v[0], rxr);
			chk("tx_run", v[3], txr);
			chk("rx_burst", 32 << v[2:1], rxb);
			chk("tx_burst", 32 << v[5:4], txb);
			chk("port_sel", v[11:7] < 16 ? 1 << v[11:7] : 0, tps);
			chk("hs_sel", v[11:8] == 4'h8 ? 1 << v[7] : 0, hs);
			chk("sel_valid", v[11:7] < 18, hs_v);
			arb(rxq, v[13:12], v[0], rxg, rx_p);
			arb(txq, v[15:14], v[3], txg, tx_p);
			@(posedge ref_clk);
			rxq <= '0;
			txq <= '0;
			pir <= 0;
		end
		rd(12'h020);
		wr(RA, 16'h0001);
		rd(MA);
		@(posedge ref_clk);
		rst_n <= 0;
		@(posedge ref_clk);
		rst_n <= 1;
		rst_m = 0;
		mc_m = 0;
		#1;
		chk("oe_hw_reset", 1, oe_n);
		rd(RA);
		wr(MA, 16'h0002);
		wr(MA, 16'h000B);
		rd(MA);
		chk("rx_run", 1, rxr);
		chk("tx_run", 1, txr);
		chk("rx_burst", 64, rxb);
		chk("tx_burst", 32, txb);
		finish_test();
	end
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
endmodule : tb_top
